// file: hw/gdp_map.vh
`ifndef GDP_MAP_VH
`define GDP_MAP_VH

// Register byte offsets on the AXI4-Lite slave.
`define GDP_OFS_VIDEO_CTRL 8'h00
`define GDP_OFS_ATTR_A 8'h04
`define GDP_OFS_ATTR_B 8'h08
`define GDP_OFS_CELL_GEOM 8'h0c
`define GDP_OFS_ROW_SPLIT 8'h10
`define GDP_OFS_COL_SPLIT 8'h14
`define GDP_OFS_PEN_COL 8'h18
`define GDP_OFS_PEN_ROW 8'h1c
`define GDP_OFS_POSITION 8'h20

// Reset values of the writable registers.
`define GDP_RST_VIDEO_CTRL 8'h00
`define GDP_RST_ATTR 8'hff
`define GDP_RST_CELL_GEOM 8'h7b
`define GDP_RST_ROW_SPLIT 8'h48
`define GDP_RST_COL_SPLIT 8'hff

// Field positions in the video control register.
`define GDP_VC_SCREEN_REV 3
`define GDP_VC_EXT_ATTR 4
`define GDP_VC_RUN 5
`define GDP_VC_MODE_LO 6
`define GDP_VC_MODE_HI 7

// Display modes held in video control bits 7:6.
`define GDP_MODE_ALPHA 2'b00
`define GDP_MODE_EXTCG 2'b10
`define GDP_MODE_PIXEL 2'b11

// Attribute bit positions; every attribute is active low.
`define GDP_AT_REVERSE 0
`define GDP_AT_HALF 1
`define GDP_AT_BLANK 6
`define GDP_AT_GRAPHICS 7

// Fixed middle dot column of a block graphics cell.
`define GDP_MID_COL 4'h4

// AXI4-Lite response codes.
`define GDP_RESP_OKAY 2'b00
`define GDP_RESP_SLVERR 2'b10

`endif

// file: hw/gdp_top.v
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`include "gdp_map.vh"
// How it works
// - Video control bits 7:6 select external character mode, which steps addresses the same way as alpha mode.
// - Scan count clear pulses low during the last character of each displayed row.
// - External mode uses eight pixel bits; dots nine and ten repeat the first.
// - External pixel byte is shifted out least significant bit first.
// - External attributes in external character mode use the full upper byte.
// - Outside external character and pixel modes, attribute bit 7 active routes the byte through block graphics logic.
// - Nine block areas lit by seven data bits; bits 0 and 5 light two.
// - Row split register: upper nibble middle row start, lower nibble bottom row start.
// - Column split bit one means middle; zero means left or right by position.
// - Centre column is always middle; tenth column copies the ninth.
// - Both mode bits set: memory bits go straight out as dots, LSB first.
// - Pixel mode uses nine bits per word; tenth dot repeats the ninth.
// - Pixel mode keeps attributes; external field shrinks to seven upper bits.
// - Pixel mode disables per-character reverse video; whole-screen reverse still works.
// - Pixel mode steps memory addresses sequentially across all scan lines.
// - Light pen edge captures character column (7 bits) and row (5 bits).
// - Pen captures are readable and hold until the next pen event.
// - Attributes are active when their bit is zero.
// - Internal attributes: byte bit 7 picks latch a (0) or latch b (1).
module gdp_top #(
  parameter H_TOTAL = 7'd105,
  parameter H_DISPLAY = 7'd80,
  parameter HS_START = 7'd87,
  parameter HS_LEN = 7'd13,
  parameter V_TOTAL = 5'd26,
  parameter V_DISPLAY = 5'd25,
  parameter ADDR_W = 12
) (
  input wire mclk_i,
  input wire rst_b_i,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire [ADDR_W-1:0] mem_addr_o,
  input wire [15:0] mem_data_i,
  input wire [7:0] cgen_dots_i,
  input wire pen_i,
  output wire video_o,
  output wire half_int_b_o,
  output wire hsync_o,
  output wire scan_clear_b_o
);

  // Software visible registers.
  reg [7:0] video_control_reg_ff;
  reg [7:0] attr_latch_a_ff;
  reg [7:0] attr_latch_b_ff;
  reg [7:0] cell_geom_ff;
  reg [7:0] graphics_row_split_ff;
  reg [7:0] graphics_column_split_ff;
  reg [6:0] pen_column_capture_ff;
  reg [4:0] pen_row_capture_ff;

  // Bus slave state.
  reg aw_full_ff;
  reg w_full_ff;
  reg [7:0] aw_addr_ff;
  reg [7:0] w_data_ff;
  reg w_lane0_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;

  // Raster timing state.
  reg [3:0] dot_ff;
  reg [6:0] chr_ff;
  reg [3:0] scan_ff;
  reg [4:0] row_ff;
  reg [ADDR_W-1:0] addr_ff;
  reg [ADDR_W-1:0] row_base_ff;
  reg [15:0] word_ff;
  reg cell_on_ff;
  reg video_ff;
  reg half_b_ff;
  reg hsync_ff;
  reg scan_clr_b_ff;
  reg pen_s1_ff;
  reg pen_s2_ff;
  reg pen_s3_ff;

  // Decoded controls.
  wire [1:0] mode = video_control_reg_ff[`GDP_VC_MODE_HI:`GDP_VC_MODE_LO];
  wire is_pixel = (mode == `GDP_MODE_PIXEL);
  wire is_extcg = (mode == `GDP_MODE_EXTCG);
  wire run = video_control_reg_ff[`GDP_VC_RUN];
  wire ext_attr = video_control_reg_ff[`GDP_VC_EXT_ATTR];
  wire [3:0] width_m1 = cell_geom_ff[7:4];
  wire [3:0] height_m1 = cell_geom_ff[3:0];
  wire [3:0] mid_start = graphics_row_split_ff[7:4];
  wire [3:0] bot_start = graphics_row_split_ff[3:0];

  // Write channel handshakes; a new write waits until the previous answer is taken.
  assign s_axi_awready = ~aw_full_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_full_ff & ~bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  wire do_write = aw_full_ff & w_full_ff & ~bvalid_ff;
  wire wr_mapped = (aw_addr_ff == `GDP_OFS_VIDEO_CTRL) || (aw_addr_ff == `GDP_OFS_ATTR_A) ||
                   (aw_addr_ff == `GDP_OFS_ATTR_B) || (aw_addr_ff == `GDP_OFS_CELL_GEOM) ||
                   (aw_addr_ff == `GDP_OFS_ROW_SPLIT) || (aw_addr_ff == `GDP_OFS_COL_SPLIT) ||
                   (aw_addr_ff == `GDP_OFS_PEN_COL) || (aw_addr_ff == `GDP_OFS_PEN_ROW) ||
                   (aw_addr_ff == `GDP_OFS_POSITION);

  // Address and data are caught separately so either may arrive first.
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 8'h00;
      w_lane0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `GDP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_ff <= 1'b1;
        w_data_ff <= s_axi_wdata[7:0];
        w_lane0_ff <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_full_ff <= 1'b0;
        w_full_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_mapped ? `GDP_RESP_OKAY : `GDP_RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Register writes; only byte lane 0 carries data since every writable register is eight bits wide.
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      video_control_reg_ff <= `GDP_RST_VIDEO_CTRL;
      attr_latch_a_ff <= `GDP_RST_ATTR;
      attr_latch_b_ff <= `GDP_RST_ATTR;
      cell_geom_ff <= `GDP_RST_CELL_GEOM;
      graphics_row_split_ff <= `GDP_RST_ROW_SPLIT;
      graphics_column_split_ff <= `GDP_RST_COL_SPLIT;
    end else if (do_write && w_lane0_ff) begin
      case (aw_addr_ff)
        `GDP_OFS_VIDEO_CTRL: video_control_reg_ff <= w_data_ff;
        `GDP_OFS_ATTR_A: attr_latch_a_ff <= w_data_ff;
        `GDP_OFS_ATTR_B: attr_latch_b_ff <= w_data_ff;
        `GDP_OFS_CELL_GEOM: cell_geom_ff <= w_data_ff;
        `GDP_OFS_ROW_SPLIT: graphics_row_split_ff <= w_data_ff;
        `GDP_OFS_COL_SPLIT: graphics_column_split_ff <= w_data_ff;
        default: ;
      endcase
    end
  end

  // Read data multiplexer; unused upper bits read as zero.
  reg [31:0] nxt_rdata;
  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (s_axi_araddr)
      `GDP_OFS_VIDEO_CTRL: nxt_rdata = {24'h00_0000, video_control_reg_ff};
      `GDP_OFS_ATTR_A: nxt_rdata = {24'h00_0000, attr_latch_a_ff};
      `GDP_OFS_ATTR_B: nxt_rdata = {24'h00_0000, attr_latch_b_ff};
      `GDP_OFS_CELL_GEOM: nxt_rdata = {24'h00_0000, cell_geom_ff};
      `GDP_OFS_ROW_SPLIT: nxt_rdata = {24'h00_0000, graphics_row_split_ff};
      `GDP_OFS_COL_SPLIT: nxt_rdata = {24'h00_0000, graphics_column_split_ff};
      `GDP_OFS_PEN_COL: nxt_rdata = {25'h000_0000, pen_column_capture_ff};
      `GDP_OFS_PEN_ROW: nxt_rdata = {27'h000_0000, pen_row_capture_ff};
      `GDP_OFS_POSITION: nxt_rdata = {16'h0000, 3'h0, row_ff, scan_ff, chr_ff[3:0]};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  // Read answer one cycle after the address is taken.
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `GDP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= nxt_rdata;
      rresp_ff <= (s_axi_araddr > `GDP_OFS_POSITION || s_axi_araddr[1:0] != 2'b00) ?
                  `GDP_RESP_SLVERR : `GDP_RESP_OKAY;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Next raster position; the character rate is the last-dot enable.
  wire last_dot = (dot_ff == width_m1);
  wire last_chr = (chr_ff == H_TOTAL - 7'd1);
  wire last_scan = (scan_ff == height_m1);
  wire last_row = (row_ff == V_TOTAL - 5'd1);
  // Clear one character early so the outside counter is zero at the next row's first fetch.
  wire clr_slot = (chr_ff == H_TOTAL - 7'd2); // Sync must rise before this slot.
  reg [6:0] nxt_chr;
  reg [3:0] nxt_scan;
  reg [4:0] nxt_row;
  always @* begin
    nxt_chr = last_chr ? 7'd0 : chr_ff + 7'd1;
    nxt_scan = scan_ff;
    nxt_row = row_ff;
    if (last_chr) begin
      nxt_scan = last_scan ? 4'd0 : scan_ff + 4'd1;
      if (last_scan) begin
        nxt_row = last_row ? 5'd0 : row_ff + 5'd1;
      end
    end
  end
  wire fetch = last_dot && (nxt_chr < H_DISPLAY) && (nxt_row < V_DISPLAY);
  wire end_disp = last_dot && (nxt_chr == H_DISPLAY) && (row_ff < V_DISPLAY);

  // Counters, fetch and address stepping. Addresses are reloaded at the end of the
  // displayed part of a line so the reload never collides with the next fetch.
  always @(posedge mclk_i) begin
    if (!rst_b_i || !run) begin
      dot_ff <= 4'd0;
      chr_ff <= 7'd0;
      scan_ff <= 4'd0;
      row_ff <= 5'd0;
      addr_ff <= {ADDR_W{1'b0}};
      row_base_ff <= {ADDR_W{1'b0}};
      word_ff <= 16'h0000;
      cell_on_ff <= 1'b0;
    end else begin
      dot_ff <= last_dot ? 4'd0 : dot_ff + 4'd1;
      if (last_dot) begin
        chr_ff <= nxt_chr;
        scan_ff <= nxt_scan;
        row_ff <= nxt_row;
        cell_on_ff <= fetch;
      end
      if (fetch) begin
        word_ff <= mem_data_i;
        addr_ff <= addr_ff + {{(ADDR_W-1){1'b0}}, 1'b1};
      end
      if (end_disp) begin
        if (last_scan && row_ff == V_DISPLAY - 5'd1) begin
          addr_ff <= {ADDR_W{1'b0}};
          row_base_ff <= {ADDR_W{1'b0}};
        end else if (is_pixel) begin
          row_base_ff <= addr_ff;
        end else if (last_scan) begin
          row_base_ff <= addr_ff;
        end else begin
          addr_ff <= row_base_ff;
        end
      end
    end
  end

  // Attribute source for the current cell.
  reg [7:0] attr;
  always @* begin
    if (ext_attr && is_pixel) begin
      attr = {word_ff[15:9], 1'b1};
    end else if (ext_attr) begin
      attr = word_ff[15:8];
    end else begin
      attr = word_ff[7] ? attr_latch_b_ff : attr_latch_a_ff;
    end
    if (is_pixel) begin
      attr[`GDP_AT_REVERSE] = 1'b1;
    end
  end

  // Block graphics area lookup.
  wire [3:0] col = (dot_ff > 4'd8) ? 4'd8 : dot_ff;
  reg [1:0] col_sec;
  reg [1:0] row_sec;
  reg blk_dot;
  always @* begin
    if (col == `GDP_MID_COL) begin
      col_sec = 2'd1;
    end else if (col < `GDP_MID_COL) begin
      col_sec = graphics_column_split_ff[col[2:0]] ? 2'd1 : 2'd0;
    end else begin
      col_sec = graphics_column_split_ff[col[2:0] - 3'd1] ? 2'd1 : 2'd2;
    end
    if (scan_ff < mid_start) begin
      row_sec = 2'd0;
    end else if (scan_ff < bot_start) begin
      row_sec = 2'd1;
    end else begin
      row_sec = 2'd2;
    end
    case ({row_sec, col_sec})
      4'h0: blk_dot = word_ff[0];
      4'h1: blk_dot = word_ff[0];
      4'h2: blk_dot = word_ff[1];
      4'h4: blk_dot = word_ff[2];
      4'h5: blk_dot = word_ff[3];
      4'h6: blk_dot = word_ff[4];
      4'h8: blk_dot = word_ff[5];
      4'h9: blk_dot = word_ff[5];
      4'ha: blk_dot = word_ff[6];
      default: blk_dot = 1'b0;
    endcase
  end

  // Dot selection per mode.
  reg raw_dot;
  always @* begin
    if (is_pixel) begin
      raw_dot = (dot_ff > 4'd8) ? word_ff[8] : word_ff[dot_ff];
    end else if (is_extcg) begin
      raw_dot = (dot_ff > 4'd7) ? word_ff[0] : word_ff[dot_ff[2:0]];
    end else if (!attr[`GDP_AT_GRAPHICS]) begin
      raw_dot = blk_dot;
    end else begin
      raw_dot = (dot_ff > 4'd7) ? 1'b0 : cgen_dots_i[dot_ff[2:0]];
    end
  end
  wire cell_rev = ~attr[`GDP_AT_REVERSE];
  wire scr_rev = video_control_reg_ff[`GDP_VC_SCREEN_REV];
  wire shown = cell_on_ff & attr[`GDP_AT_BLANK];

  // Output stage; the blanked raster area stays low whatever whole-screen reverse video is set to.
  always @(posedge mclk_i) begin
    if (!rst_b_i || !run) begin
      video_ff <= 1'b0;
      half_b_ff <= 1'b1;
      hsync_ff <= 1'b0;
      scan_clr_b_ff <= 1'b1;
    end else begin
      if (cell_on_ff) begin
        video_ff <= ((shown & raw_dot) ^ cell_rev) ^ scr_rev;
      end else begin
        video_ff <= 1'b0;
      end
      half_b_ff <= ~(cell_on_ff & ~attr[`GDP_AT_HALF]);
      hsync_ff <= (chr_ff >= HS_START) && (chr_ff < HS_START + HS_LEN);
      scan_clr_b_ff <= ~(last_dot && clr_slot && last_scan && row_ff < V_DISPLAY);
    end
  end

  // Light pen: two-stage synchroniser, then a rising edge latches the position.
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      pen_s1_ff <= 1'b0;
      pen_s2_ff <= 1'b0;
      pen_s3_ff <= 1'b0;
      pen_column_capture_ff <= 7'h00;
      pen_row_capture_ff <= 5'h00;
    end else begin
      pen_s1_ff <= pen_i;
      pen_s2_ff <= pen_s1_ff;
      pen_s3_ff <= pen_s2_ff;
      if (pen_s2_ff && !pen_s3_ff) begin
        pen_column_capture_ff <= chr_ff;
        pen_row_capture_ff <= row_ff;
      end
    end
  end

  assign mem_addr_o = addr_ff;
  assign video_o = video_ff;
  assign half_int_b_o = half_b_ff;
  assign hsync_o = hsync_ff;
  assign scan_clear_b_o = scan_clr_b_ff;

endmodule

// file: test/gdp_mem_model.sv
`timescale 1ns/10ps
// Display memory plus an outside glyph ROM; a scan counter only alters the external mode pixel byte.
module gdp_mem_model (
  input wire mclk_i,
  input wire rst_b_i,
  input wire [11:0] mem_addr_i,
  input wire hsync_i,
  input wire scan_clear_b_i,
  input wire ext_mode_i,
  output logic [15:0] mem_data_o,
  output logic [7:0] cgen_dots_o
);
  logic [8:0] mem [0:63];
  logic [3:0] scan_ff;
  logic hs_ff;
  logic [8:0] word;
  // The counter clears on the strobe and steps on each rising sync edge.
  always @(posedge mclk_i) begin
    hs_ff <= hsync_i;
    if (!rst_b_i || !scan_clear_b_i) begin
      scan_ff <= 4'h0;
    end else if (hsync_i && !hs_ff) begin
      scan_ff <= scan_ff + 4'h1;
    end
  end
  // Only six address bits decode, so the space mirrors every 64 cells.
  always @* begin
    word = mem[mem_addr_i[5:0]];
    mem_data_o = {7'h7f, word};
    if (ext_mode_i) begin
      mem_data_o[7:0] = word[7:0] ^ {scan_ff, scan_ff};
    end
    cgen_dots_o = ~word[7:0];
  end
endmodule

// file: test/gdp_top_sva.sv
`timescale 1ns/10ps
// Watches the register handshakes and the raster strobes of the dot path.
module gdp_top_sva (
  input wire mclk_i,
  input wire rst_b_i,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire video_o,
  input wire half_int_b_o,
  input wire hsync_o,
  input wire scan_clear_b_o
);
  // Everything here belongs to the one dot clock.
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  chk_clear_one_cycle: assert property ($fell(scan_clear_b_o) |=> scan_clear_b_o[*8])
    else $error("scan clear strobe wider than one cycle");
  chk_reset_idle: assert property ($rose(rst_b_i) |-> !video_o && half_int_b_o
    && scan_clear_b_o && !hsync_o && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not idle after reset");
  chk_sync_width: assert property ($rose(hsync_o) |-> hsync_o[*8])
    else $error("horizontal sync shorter than a character");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped or changed");
  chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");
  chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("second write accepted");
  chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp))
    else $error("write answer dropped or changed");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write answer missing");
endmodule
bind gdp_top gdp_top_sva u_sva (.*);

// file: test/tb_gdp_top.sv
`timescale 1ns/10ps
`include "gdp_map.vh"
// Counts one comparison and reports a mismatch at once.
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_gdp_top;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  wire s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  wire s_axi_wready;
  wire [1:0] s_axi_bresp;
  wire s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  wire s_axi_arready;
  wire [31:0] s_axi_rdata;
  wire [1:0] s_axi_rresp;
  wire s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  wire [11:0] mem_addr_o;
  wire [15:0] mem_data_i;
  wire [7:0] cgen_dots_i;
  logic pen_i = 1'b0;
  wire video_o;
  wire half_int_b_o;
  wire hsync_o;
  wire scan_clear_b_o;
  logic ext_mode = 1'b0;
  int err_total = 0;
  int comparisons = 0;
  integer seed = 89;
  logic [7:0] cs_v;
  logic [1:0] rsp;
  logic [31:0] rd, keep;
  logic [31:0] pr [0:2];
  logic [31:0] pc [0:2];
  logic [7:0] vc_t [0:7] = '{8'ha0, 8'hb0, 8'he0, 8'hf8, 8'h20, 8'h20, 8'h20, 8'h20};
  logic [7:0] lat_t [0:7] = '{8'hfe, 8'hff, 8'hfe, 8'hff, 8'h7f, 8'h7f, 8'h7f, 8'hfd};
  logic [7:0] rs_t [0:7] = '{8'h48, 8'h48, 8'h48, 8'h48, 8'h48, 8'h02, 8'h00, 8'h48};
  logic [7:0] adr_t [0:6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'he4};
  logic [7:0] rst_t [0:6] = '{`GDP_RST_VIDEO_CTRL, `GDP_RST_ATTR, `GDP_RST_ATTR,
    `GDP_RST_CELL_GEOM, `GDP_RST_ROW_SPLIT, `GDP_RST_COL_SPLIT, 8'h00};
  // Short raster so a frame is four rows of twelve characters.
  gdp_top #(.H_TOTAL(7'd12), .H_DISPLAY(7'd8), .HS_START(7'd9), .HS_LEN(7'd2),
    .V_TOTAL(5'd4), .V_DISPLAY(5'd3)) dut (.*);
  gdp_mem_model u_mem (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .mem_addr_i(mem_addr_o),
    .hsync_i(hsync_o), .scan_clear_b_i(scan_clear_b_o), .ext_mode_i(ext_mode),
    .mem_data_o(mem_data_i), .cgen_dots_o(cgen_dots_i));
  // Free running dot clock of 100 ns.
  initial forever #50 mclk_i = ~mclk_i;
  task automatic end_sim;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  task automatic fail_wait;
    begin
      err_total++;
      $display("[ERR] handshake wait exp done got timeout");
      end_sim;
    end
  endtask
  // Ready is looked at mid-cycle, which equals its value at the next rising edge.
  task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [3:0] st,
                     output logic [1:0] r);
    int n;
    logic ah, wh, bd;
    logic [31:0] rn;
    begin
      bd = 1'b0;
      rn = $random(seed);
      @(posedge mclk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= {rn[31:8], d};
      s_axi_wstrb <= {rn[3:1], st[0]};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= rn[4];
      for (n = 0; n < 50 && !bd; n++) begin
        @(negedge mclk_i);
        ah = s_axi_awvalid && s_axi_awready;
        wh = s_axi_wvalid && s_axi_wready;
        bd = s_axi_bvalid && s_axi_bready;
        r = s_axi_bresp;
        @(posedge mclk_i);
        if (ah) s_axi_awvalid <= 1'b0;
        if (wh) s_axi_wvalid <= 1'b0;
        s_axi_bready <= !bd;
      end
      if (!bd) fail_wait;
    end
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ah, dn;
    logic [31:0] rn;
    begin
      dn = 1'b0;
      rn = $random(seed);
      @(posedge mclk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= rn[0];
      for (n = 0; n < 50 && !dn; n++) begin
        @(negedge mclk_i);
        ah = s_axi_arvalid && s_axi_arready;
        dn = s_axi_rvalid && s_axi_rready;
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge mclk_i);
        if (ah) s_axi_arvalid <= 1'b0;
        s_axi_rready <= !dn;
      end
      if (!dn) fail_wait;
    end
  endtask
  task automatic wait_clear;
    int n;
    begin
      @(negedge mclk_i);
      for (n = 0; n < 3000 && scan_clear_b_o !== 1'b0; n++) @(negedge mclk_i);
      if (n == 3000) fail_wait;
    end
  endtask
  // Expected dots of one line of eight ten-dot cells, first dot at bit 0.
  function automatic logic [79:0] exp_line(input int s, input int r, input logic [3:0] c);
    logic [8:0] w, n;
    logic [7:0] v, b;
    logic dot, rev;
    int k, d, col, rsec, idx;
    begin
      v = vc_t[s];
      rsec = (rs_t[s][7:4] != 0) ? 0 : (rs_t[s][3:0] != 0) ? 1 : 2;
      for (k = 0; k < 8; k++) begin
        w = u_mem.mem[((v[7:6] == 2'b11 ? 32 : 8) * r + k) % 64];
        n = u_mem.mem[(8 * r + k + 1) % 64]; // Glyph ROM sees the next cell's address.
        b = w[7:0] ^ {c, c};
        rev = ~(lat_t[s][0] ^ (s == 7 && w[7]));
        if (v[4]) rev = ~w[8];
        if (v[7:6] == 2'b11) rev = 1'b0;
        for (d = 0; d < 10; d++) begin
          col = (d < 4) ? (cs_v[d] ? 1 : 0) : (d == 4) ? 1 : (cs_v[d > 8 ? 7 : d - 1] ? 1 : 2);
          idx = (rsec == 1) ? 2 + col : (rsec == 0 ? 0 : 5) + (col == 2 ? 1 : 0);
          if (v[7:6] == 2'b11) dot = (d < 9) ? w[d] : w[8];
          else if (v[7:6] == 2'b10) dot = (d < 8) ? b[d] : b[0];
          else if (lat_t[s][7]) dot = (d < 8) ? ~n[d] : 1'b0;
          else dot = w[idx];
          exp_line[k * 10 + d] = dot ^ rev ^ v[3];
        end
      end
    end
  endfunction
  // Of three row strobes, the lines after the first two of the three displayed rows must match.
  task automatic scene(input int s);
    logic [129:0] cap;
    logic [79:0] e;
    logic hit;
    int hits, i, r, c, off, lows;
    begin
      hits = 0;
      lows = 0;
      repeat (3) begin
        wait_clear;
        for (i = 0; i < 130; i++) begin
          @(negedge mclk_i);
          cap[i] = video_o;
          lows += (half_int_b_o === 1'b0);
        end
        hit = 1'b0;
        for (r = 1; r < 3; r++) begin
          for (c = 0; c < 2; c++) begin
            e = exp_line(s, r, c);
            for (off = 0; off < 51; off++) if (cap[off +: 80] === e) hit = 1'b1;
          end
        end
        hits += hit;
      end
      `CHK("matching lines", 2, hits)
      `CHK("half lows", (!vc_t[s][4] && !lat_t[s][1]) ? 160 : 0, lows)
    end
  endtask
  // Register checks, then every display mode, then the pen capture.
  initial begin
    for (int i = 0; i < 64; i++) u_mem.mem[i] = $random(seed);
    repeat (5) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      axr(adr_t[i], rd, rsp);
      `CHK("reset value", {24'h0, rst_t[i]}, rd)
      `CHK("read resp", (i == 6) ? `GDP_RESP_SLVERR : `GDP_RESP_OKAY, rsp)
    end
    axw(`GDP_OFS_COL_SPLIT, 8'h3c, 4'h0, rsp);
    axr(`GDP_OFS_COL_SPLIT, rd, rsp);
    `CHK("masked write", {24'h0, `GDP_RST_COL_SPLIT}, rd)
    axw(8'hc8, 8'h11, 4'hf, rsp);
    `CHK("unmapped write", `GDP_RESP_SLVERR, rsp)
    axr(`GDP_OFS_PEN_COL, keep, rsp);
    axw(`GDP_OFS_PEN_COL, ~keep[7:0], 4'hf, rsp);
    axr(`GDP_OFS_PEN_COL, rd, rsp);
    `CHK("pen read only", keep, rd)
    axw(`GDP_OFS_ROW_SPLIT, 8'h5a, 4'hf, rsp);
    axr(`GDP_OFS_ROW_SPLIT, rd, rsp);
    `CHK("row split", 32'h5a, rd)
    axw(`GDP_OFS_CELL_GEOM, 8'h93, 4'hf, rsp);
    for (int s = 0; s < 8; s++) begin
      cs_v = (s == 4) ? 8'h00 : $random(seed);
      axw(`GDP_OFS_ATTR_A, lat_t[s], 4'hf, rsp);
      axw(`GDP_OFS_ATTR_B, lat_t[s] ^ {7'h00, s == 7}, 4'hf, rsp);
      axw(`GDP_OFS_ROW_SPLIT, rs_t[s], 4'hf, rsp);
      axw(`GDP_OFS_COL_SPLIT, cs_v, 4'hf, rsp);
      ext_mode <= (vc_t[s][7:6] == 2'b10);
      axw(`GDP_OFS_VIDEO_CTRL, vc_t[s], 4'hf, rsp);
      scene(s);
    end
    for (int i = 0; i < 3; i++) begin
      wait_clear;
      @(posedge mclk_i);
      pen_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      pen_i <= 1'b0;
      repeat (20) @(posedge mclk_i);
      axr(`GDP_OFS_PEN_ROW, pr[i], rsp);
      axr(`GDP_OFS_PEN_COL, pc[i], rsp);
    end
    `CHK("pen column", pc[0], pc[1])
    `CHK("pen col width", 25'h0, pc[0][31:7])
    `CHK("pen row step", 1'b1, (pr[1] == pr[0] + 1) || (pr[2] == pr[1] + 1))
    repeat (600) @(posedge mclk_i);
    axr(`GDP_OFS_PEN_ROW, rd, rsp);
    `CHK("pen row hold", pr[2], rd)
    end_sim;
  end
endmodule
